// ---- include/fsw_map.svh ----
/*
  constants of the fail-safe watchdog: widths, divider settings, reset values, timing.
  assumes: included by bare name from the package and the design modules.
*/
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH

`define FSW_CNT_W          16
`define FSW_CNT_MAX        16'hFFFF
`define FSW_CNT_ZERO       16'h0000
`define FSW_PRE_W          14
`define FSW_DIV_SLOW_LOG   14
`define FSW_DIV_FAST_LOG   8
`define FSW_SEL_SLOW       1'b0
`define FSW_SEL_FAST       1'b1
`define FSW_SEL_RST        1'b1
`define FSW_RELOAD_RST     16'hFF02
`define FSW_WARN_CYCLES    16'h0100
`define FSW_WARN_CNT_W     16
`define FSW_DEF_INTERVAL_US 6500
`define FSW_POWERUP_MHZ    10
`define FSW_DEF_TOL_CYC    200

`endif

// ---- include/fsw_pkg.sv ----
/*
  types shared by the watchdog modules.
  assumes: fsw_map.svh on the include path.
*/
`include "fsw_map.svh"

package fsw_pkg;

  typedef enum logic [1:0] {
    FSW_RUN,
    FSW_STOP,
    FSW_WARN,
    FSW_RESET
  } fsw_state_type;

  typedef logic [`FSW_CNT_W-1:0] fsw_count_type;

endpackage : fsw_pkg

// ---- include/fsw_tick_if.sv ----
/*
  tick link between the watchdog core and its prescaler.
  assumes: both ends on the same clock.
*/
interface fsw_tick_if;
  logic clr;
  logic sel;
  logic tick;

  modport ctl (output clr, output sel, input tick);
  modport pre (input clr, input sel, output tick);
endinterface : fsw_tick_if

// ---- core/fsw_prescaler.sv ----
/*
  prescaler of the watchdog: divides the system clock by 16384 or 256.
  assumes: clr and sel come from logic on the same clock.
*/
`include "fsw_map.svh"

module fsw_prescaler
  import fsw_pkg::*;
#(
  parameter int SLOW_LOG = `FSW_DIV_SLOW_LOG,
  parameter int FAST_LOG = `FSW_DIV_FAST_LOG
) (
  input  wire logic  MCLK,
  input  wire logic  RST_N,
  fsw_tick_if.pre    pre
);

  logic [`FSW_PRE_W-1:0] div_cnt;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= '0;
    end else if (pre.clr) begin
      div_cnt <= '0; // see R7
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // tick on the last cycle of each divided period
  assign pre.tick = !pre.clr && ((pre.sel == `FSW_SEL_FAST) ? (&div_cnt[FAST_LOG-1:0]) :
                                                              (&div_cnt[SLOW_LOG-1:0])); // see R5

  // helper: cycles since the last tick or clear; clean drops on a change of selection
  logic [`FSW_PRE_W-1:0] gap;
  logic                  clean;
  logic                  sel_q;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gap   <= '0;
      clean <= 1'b0;
      sel_q <= `FSW_SEL_RST;
    end else begin
      sel_q <= pre.sel;
      if (pre.clr || pre.tick) begin
        gap   <= '0;
        clean <= 1'b1;
      end else begin
        gap <= gap + 1'b1;
      end
      if (pre.sel != sel_q) begin
        clean <= 1'b0;
      end
    end
  end

  tick_period_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R5
    (pre.tick && clean && pre.sel == sel_q) |->
      (gap == ((pre.sel == `FSW_SEL_FAST) ? (`FSW_PRE_W)'((1 << FAST_LOG) - 1) :
                                            (`FSW_PRE_W)'((1 << SLOW_LOG) - 1))))
    else $error("prescaler tick period wrong");

endmodule // fsw_prescaler

// ---- core/fsw_watchdog.sv ----
/*
  fail-safe watchdog: 16-bit up counter on a prescaled tick, prewarning then reset request.
  assumes: instruction strobes and register writes are one-cycle pulses from the core on MCLK.
*/
// Functional notes
// R1: watchdog runs after every application reset without software action.
// R2: disable instruction stops it, enable instruction restarts it, at any time; code ignores disable sent with enable or on overflow.
// R3: software must service the watchdog before the counter overflows.
// R4: unserviced overflow raises prewarning interrupt, then a reset request.
// R5: 16-bit counter on prescaled tick, divider 16384 or 256 selectable.
// R6: counter loads from the programmable interval reload register.
// R7: each service reloads the counter and clears the prescaler together; code ignores service in FSW_WARN and FSW_RESET.
// R8: reset defaults give a 6.5 ms interval at 10 MHz.
// R9: counter counts up from reload; overflow is all ones to zero.
`include "fsw_map.svh"

module fsw_watchdog
  import fsw_pkg::*;
#(
  parameter int CNT_W       = `FSW_CNT_W,
  parameter int WARN_CYCLES = `FSW_WARN_CYCLES
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  input  wire logic                  SERVICE_INSTRUCTION,
  input  wire logic                  GUARD_DISABLE_INSTRUCTION,
  input  wire logic                  GUARD_ENABLE_INSTRUCTION,
  input  wire logic                  RELOAD_WR,
  input  wire logic [`FSW_CNT_W-1:0] RELOAD_DATA,
  input  wire logic                  PRESEL_WR,
  input  wire logic                  PRESEL_DATA,
  output logic      [`FSW_CNT_W-1:0] COUNT,
  output logic                       RUNNING,
  output logic                       PRESEL,
  output logic      [`FSW_CNT_W-1:0] RELOAD,
  output logic                       PREWARN_IRQ,
  output logic                       RESET_REQ
);

  localparam int WARN_N = WARN_CYCLES;

  fsw_tick_if tick_if ();

  fsw_prescaler u_pre (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .pre   (tick_if.pre)
  );

  fsw_state_type              state;
  fsw_state_type              next_state;
  fsw_count_type              count;
  fsw_count_type              next_count;
  fsw_count_type              interval_reload_register;
  logic                       presel;
  logic [`FSW_WARN_CNT_W-1:0] warn_cnt;
  logic                       svc_ok;
  logic                       overflow;
  logic                       warn_done;

  // service is ignored once the prewarning is out: the failure is already committed
  assign svc_ok    = SERVICE_INSTRUCTION && (state == FSW_RUN || state == FSW_STOP);
  assign overflow  = (state == FSW_RUN) && tick_if.tick && !SERVICE_INSTRUCTION &&
                     (count == `FSW_CNT_MAX); // see R4
  assign warn_done = (state == FSW_WARN) &&
                     (warn_cnt == (`FSW_WARN_CNT_W)'(WARN_CYCLES - 1));

  // prescaler held clear while stopped, so enable restarts a whole tick period
  assign tick_if.clr = svc_ok || (state != FSW_RUN); // see R7
  assign tick_if.sel = presel;

  // reload and divider selection, written by the core
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      interval_reload_register <= `FSW_RELOAD_RST; // see R8
      presel                   <= `FSW_SEL_RST; // see R8
    end else begin
      if (RELOAD_WR) begin
        interval_reload_register <= RELOAD_DATA;
      end
      if (PRESEL_WR) begin
        presel <= PRESEL_DATA; // see R5
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      FSW_RUN: begin
        if (overflow) begin
          next_state = FSW_WARN; // see R4
        end else if (GUARD_DISABLE_INSTRUCTION && !GUARD_ENABLE_INSTRUCTION) begin
          next_state = FSW_STOP; // see R2
        end
      end
      FSW_STOP: begin
        if (GUARD_ENABLE_INSTRUCTION) begin
          next_state = FSW_RUN; // see R2
        end
      end
      FSW_WARN: begin
        if (warn_done) begin
          next_state = FSW_RESET; // see R4
        end
      end
      FSW_RESET: begin
        next_state = FSW_RESET;
      end
      default: begin
        next_state = FSW_RUN;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= FSW_RUN; // see R1
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_count = count;
    if (svc_ok) begin
      next_count = interval_reload_register; // see R6
    end else if (state == FSW_RUN && tick_if.tick) begin
      next_count = count + 1'b1; // see R9
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= `FSW_RELOAD_RST; // see R6
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      warn_cnt <= '0;
    end else if (state == FSW_WARN) begin
      warn_cnt <= warn_cnt + 1'b1;
    end else begin
      warn_cnt <= '0;
    end
  end

  // outputs, all registered
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      COUNT       <= `FSW_RELOAD_RST;
      RUNNING     <= 1'b1; // see R1
      PRESEL      <= `FSW_SEL_RST;
      RELOAD      <= `FSW_RELOAD_RST;
      PREWARN_IRQ <= 1'b0;
      RESET_REQ   <= 1'b0;
    end else begin
      COUNT       <= next_count;
      RUNNING     <= (next_state == FSW_RUN);
      PRESEL      <= PRESEL_WR ? PRESEL_DATA : presel;
      RELOAD      <= RELOAD_WR ? RELOAD_DATA : interval_reload_register;
      PREWARN_IRQ <= overflow; // see R4
      RESET_REQ   <= (next_state == FSW_RESET); // see R4
    end
  end

  // helper for checks: high during the first cycle after reset release
  logic after_rst;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      after_rst <= 1'b1;
    end else begin
      after_rst <= 1'b0;
    end
  end

  // cycles of a whole default interval from the reset values
  logic [31:0] def_cycles;
  assign def_cycles = (32'h0001_0000 - {16'h0000, interval_reload_register}) <<
                      ((presel == `FSW_SEL_FAST) ? `FSW_DIV_FAST_LOG : `FSW_DIV_SLOW_LOG);

  localparam int DEF_CYC = `FSW_DEF_INTERVAL_US * `FSW_POWERUP_MHZ;
  localparam int DEF_TOL = `FSW_DEF_TOL_CYC;

  sequence ovf_seq;
    overflow;
  endsequence

  sequence warn_seq;
    ##1 PREWARN_IRQ && !RESET_REQ ##1 !PREWARN_IRQ;
  endsequence

  boot_running_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R1
    after_rst |-> (RUNNING && state == FSW_RUN))
    else $error("watchdog not running after reset");

  disable_stops_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R2
    (state == FSW_RUN && !overflow && GUARD_DISABLE_INSTRUCTION && !GUARD_ENABLE_INSTRUCTION)
      |=> (!RUNNING && state == FSW_STOP) ##1
          (state != FSW_STOP || $stable(count) || $past(svc_ok)))
    else $error("disable did not stop the counter");

  enable_runs_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R2
    (state == FSW_STOP && GUARD_ENABLE_INSTRUCTION) |=> (RUNNING && state == FSW_RUN))
    else $error("enable did not restart the counter");

  prewarn_reset_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R4
    ovf_seq |-> warn_seq ##(WARN_N - 1) RESET_REQ)
    else $error("prewarning or reset request out of order");

  reload_load_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R6
    svc_ok |=> (COUNT == $past(interval_reload_register)))
    else $error("service did not load the reload value");

  service_clear_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R7
    svc_ok |=> !tick_if.tick [*8])
    else $error("prescaler not cleared by service");

  default_interval_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R8
    after_rst |-> (def_cycles >= 32'(DEF_CYC - DEF_TOL) && def_cycles <= 32'(DEF_CYC + DEF_TOL)))
    else $error("default interval not 6.5 ms at 10 MHz");

  count_up_a : assert property (@(posedge MCLK) disable iff (!RST_N) // see R9
    (state == FSW_RUN && tick_if.tick && !SERVICE_INSTRUCTION) |=>
      (COUNT == fsw_count_type'($past(count) + 1'b1)) && (($past(count) == `FSW_CNT_MAX) ==
      (COUNT == `FSW_CNT_ZERO)))
    else $error("counter did not step up by one");

endmodule // fsw_watchdog

// ---- sim/fsw_core_model.sv ----
/*
  core-side model: issues the watchdog instructions and reload/divider writes as strobes.
  assumes: mclk is the watchdog clock; strobes change just after a rising edge.
*/
module fsw_core_model (
  input  wire logic        mclk,
  output logic             svc,
  output logic             dis,
  output logic             ena,
  output logic             rel_wr,
  output logic [15:0]      rel_data,
  output logic             sel_wr,
  output logic             sel_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {svc, dis, ena, rel_wr, sel_wr, sel_data} = 6'h00;
    rel_data = 16'h0000;
  end

  // s bits: service, disable, enable, reload write, divider write
  // one-cycle pulse; callers service well before overflow
  task automatic op(input logic [4:0] s, input logic [15:0] d);
    @(posedge mclk);
    {svc, dis, ena, rel_wr, sel_wr} <= s;
    rel_data <= d;
    sel_data <= d[0];
    @(posedge mclk);
    {svc, dis, ena, rel_wr, sel_wr} <= 5'h00;
    // data lines driven to the inverse once released
    rel_data <= ~d;
    sel_data <= ~d[0];
  endtask
endmodule // fsw_core_model

// ---- sim/tb.sv ----
/*
  self-checking bench of the watchdog: reset state, dividers, service, on/off, overflow.
  assumes: the core model drives all strobes; reset control is done here.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] SVC = 5'h10, DIS = 5'h08, ENA = 5'h04, REL = 5'h02, SEL = 5'h01;
  logic        mclk, rst_n, svc, dis, ena, rel_wr, sel_wr, sel_data;
  logic [15:0] rel_data, count, reload;
  logic        running, presel, prewarn_irq, reset_req;
  int          n_errors = 0;
  int          compares = 0;

  fsw_core_model i_core (.mclk(mclk), .svc(svc), .dis(dis), .ena(ena), .rel_wr(rel_wr),
    .rel_data(rel_data), .sel_wr(sel_wr), .sel_data(sel_data));

  fsw_watchdog i_dut (.MCLK(mclk), .RST_N(rst_n), .SERVICE_INSTRUCTION(svc),
    .GUARD_DISABLE_INSTRUCTION(dis), .GUARD_ENABLE_INSTRUCTION(ena), .RELOAD_WR(rel_wr),
    .RELOAD_DATA(rel_data), .PRESEL_WR(sel_wr), .PRESEL_DATA(sel_data), .COUNT(count),
    .RUNNING(running), .PRESEL(presel), .RELOAD(reload), .PREWARN_IRQ(prewarn_irq),
    .RESET_REQ(reset_req));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(2);
    chk(count, 16'hFF02);
    chk(reload, 16'hFF02);
    chk(16'(presel), 16'h0001);
    chk(16'(running), 16'h0001);
    chk(16'(reset_req), 16'h0000);
  endtask

  // tick lands exactly one divider period after the service edge
  task automatic s_div(input logic sel, input int lo, input int hi);
    i_core.op(SEL, {15'h0000, sel});
    i_core.op(REL, 16'hFFF0);
    i_core.op(SVC, 16'h0000);
    cyc(2);
    chk(count, 16'hFFF0);
    chk(reload, 16'hFFF0);
    chk(16'(presel), {15'h0000, sel});
    cyc(lo - 2);
    chk(count, 16'hFFF0);
    cyc(hi - lo);
    chk(count, 16'hFFF1);
  endtask

  task automatic s_svc;
    i_core.op(SEL, 16'h0001);
    i_core.op(SVC, 16'h0000);
    cyc(200);
    // prescaler not cleared would tick 55 cycles later
    i_core.op(SVC, 16'h0000);
    cyc(200);
    chk(count, 16'hFFF0);
    i_core.op(REL, 16'hFF80);
    i_core.op(SVC, 16'h0000);
    cyc(2);
    chk(count, 16'hFF80);
  endtask

  task automatic s_onoff;
    logic [15:0] v;
    // both strobes together while running: enable wins
    i_core.op(DIS | ENA, 16'h0000);
    cyc(2);
    chk(16'(running), 16'h0001);
    i_core.op(DIS, 16'h0000);
    cyc(2);
    chk(16'(running), 16'h0000);
    v = count;
    cyc(600);
    chk(count, v);
    i_core.op(DIS | ENA, 16'h0000);
    cyc(2);
    chk(16'(running), 16'h0001);
    cyc(298);
    chk(count, v + 16'h0001);
  endtask

  // default setting run to overflow: 6.5 ms at 10 MHz is 65000 cycles
  task automatic s_ovf;
    int n;
    int m;
    t_reset();
    n = 0;
    while (prewarn_irq !== 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
    compares++;
    if (n < 64800 || n > 65200) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, n, 65000);
    end
    chk(count, 16'h0000);
    chk(16'(running), 16'h0000);
    chk(16'(reset_req), 16'h0000);
    cyc(1);
    m = 1;
    chk(16'(prewarn_irq), 16'h0000);
    while (reset_req !== 1'b1 && m < 1000) begin
      cyc(1);
      m++;
    end
    chk(16'(m), 16'h0100);
    cyc(10);
    chk(16'(reset_req), 16'h0001);
  endtask

  initial begin
    rst_n = 1'b0;
    t_reset();
    s_div(1'b1, 256, 257);
    s_div(1'b0, 16384, 16385);
    s_svc();
    s_onoff();
    s_ovf();
    print_verdict();
  end

  // all scenarios need about 83300 cycles
  initial begin
    repeat (95000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule // tb
